/* File: osfs_pkg.sv */
`default_nettype none
package osfs_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_TERM_SEL = 8'h00;
    localparam logic [7:0] OFF_OVL_LIMIT = 8'h04;
    localparam logic [7:0] OFF_VLOSS_LIMIT = 8'h08;
    localparam logic [7:0] OFF_ILOSS_LIMIT = 8'h0c;
    localparam logic [7:0] OFF_PID_LOW = 8'h10;
    localparam logic [7:0] OFF_PID_HIGH = 8'h14;
    localparam logic [7:0] OFF_WDT_PERIOD = 8'h18;
    localparam logic [7:0] OFF_LOGIC_CFG = 8'h1c;
    localparam logic [7:0] OFF_HEAT_LIMIT = 8'h20;
    localparam logic [7:0] OFF_LOWLOAD_LIMIT = 8'h24;
    localparam logic [7:0] OFF_ARRIVE_BAND = 8'h28;
    localparam logic [7:0] OFF_FLAGS = 8'h2c;
    localparam logic [7:0] OFF_INT_STATUS = 8'h30;
    localparam logic [7:0] OFF_INT_MASK = 8'h34;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_TERM_SEL = 32'hffffffff;
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    localparam logic [31:0] RST_WDT_PERIOD = 32'h0003d090;

    // ------------------------------------------------------------
    // flag bit positions
    // ------------------------------------------------------------
    localparam int FLAG_COUNT = 14;
    localparam int FB_ARRIVE = 0;
    localparam int FB_OVERLOAD = 1;
    localparam int FB_VLOSS = 2;
    localparam int FB_ILOSS = 3;
    localparam int FB_PID = 4;
    localparam int FB_NET = 5;
    localparam int FB_BOOL1 = 6;
    localparam int FB_CAP = 9;
    localparam int FB_FAN = 10;
    localparam int FB_START = 11;
    localparam int FB_HEAT = 12;
    localparam int FB_LOWLOAD = 13;

    // ------------------------------------------------------------
    // option codes and boolean operators
    // ------------------------------------------------------------
    localparam logic [7:0] OPT_ARRIVE = 8'h19;
    localparam logic [7:0] OPT_OVERLOAD = 8'h1a;
    localparam logic [7:0] OPT_VLOSS = 8'h1b;
    localparam logic [7:0] OPT_ILOSS = 8'h1c;
    localparam logic [7:0] OPT_PID = 8'h1f;
    localparam logic [7:0] OPT_NET = 8'h20;
    localparam logic [7:0] OPT_BOOL1 = 8'h21;
    localparam logic [7:0] OPT_BOOL2 = 8'h22;
    localparam logic [7:0] OPT_BOOL3 = 8'h23;
    localparam logic [7:0] OPT_CAP = 8'h27;
    localparam logic [7:0] OPT_FAN = 8'h28;
    localparam logic [7:0] OPT_START = 8'h29;
    localparam logic [7:0] OPT_HEAT = 8'h2a;
    localparam logic [7:0] OPT_LOWLOAD = 8'h2b;

    typedef enum logic [1:0] {
        OSFS_OP_AND,
        OSFS_OP_OR,
        OSFS_OP_XOR
    } osfs_bool_op_t;
endpackage
`default_nettype wire

/* File: osfs_selector.sv */
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1 - arrival flag: output on, frequency within band
// RQ2 - overload flag: current above overload limit
// RQ3 - voltage loss flag: voltage input below limit
// RQ4 - current loss flag: current input below limit
// RQ5 - pid flag sets: running, variable below low
// RQ6 - pid flag clears: above high or run-to-stop
// RQ7 - network flag: watchdog period expires without activity
// RQ8 - three boolean flags follow configured operations
// RQ9 - capacitor flag follows capacitor life expiry
// RQ10 - fan flag follows fan life expiry
// RQ11 - start flag: exactly one run command
// RQ12 - overheat flag: heat-sink above limit
// RQ13 - low load flag: motor current below limit
// RQ14 - per-terminal option code; unknown code drives inactive
module osfs_selector #(
    parameter int NUM_TERM = 2,
    parameter int DW = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic outputOn,
    input wire logic [DW-1:0] outputFreq,
    input wire logic [DW-1:0] setFreq,
    input wire logic [DW-1:0] outputCurrent,
    input wire logic [DW-1:0] voltageInput,
    input wire logic [DW-1:0] currentInput,
    input wire logic runMode,
    input wire logic [DW-1:0] process_variable,
    input wire logic commActivity,
    input wire logic [2:0] logicInA,
    input wire logic [2:0] logicInB,
    input wire logic capacitorExpired,
    input wire logic fanExpired,
    input wire logic forward_run_command,
    input wire logic reverse_run_command,
    input wire logic [DW-1:0] heatsinkTemp,
    input wire logic [DW-1:0] motorCurrent,
    output logic [NUM_TERM-1:0] termOut,
    output logic irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic wb_ack_ff;
    logic [31:0] rdData_ff;
    logic [31:0] termSel_ff;
    logic [DW-1:0] ovlLimit_ff, vlossLimit_ff, ilossLimit_ff, pidLow_ff, pidHigh_ff;
    logic [DW-1:0] heatLimit_ff, lowloadLimit_ff, arriveBand_ff;
    logic [31:0] wdtPeriod_ff, wdtCount_ff;
    logic [5:0] logicCfg_ff;
    logic [osfs_pkg::FLAG_COUNT-1:0] flags_ff, flagsPrev_ff, intStatus_ff, intMask_ff;
    logic runPrev_ff;
    logic [NUM_TERM-1:0] termOut_ff;
    logic irq_ff;

    logic busReq, wrEn;
    logic [7:0] regAdr;
    logic [31:0] byteMask;
    logic [DW-1:0] freqDiff;
    logic [2:0] boolRes;
    logic [osfs_pkg::FLAG_COUNT-1:0] nxt_flagsComb;

    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_ff;
    assign wrEn = busReq && wb_we_i;
    assign regAdr = {wb_adr_i[7:2], 2'b00};
    assign byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [31:0] m);
        merge = (old & ~m) | (dat & m);
    endfunction

    // ------------------------------------------------------------
    // wishbone slave: one wait state, unmapped reads as zero
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_ff <= 1'b0;
        end else begin
            wb_ack_ff <= busReq;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_ff <= osfs_pkg::RST_ZERO;
        end else if (busReq) begin
            if (regAdr == osfs_pkg::OFF_TERM_SEL) begin
                rdData_ff <= termSel_ff;
            end else if (regAdr == osfs_pkg::OFF_OVL_LIMIT) begin
                rdData_ff <= 32'(ovlLimit_ff);
            end else if (regAdr == osfs_pkg::OFF_VLOSS_LIMIT) begin
                rdData_ff <= 32'(vlossLimit_ff);
            end else if (regAdr == osfs_pkg::OFF_ILOSS_LIMIT) begin
                rdData_ff <= 32'(ilossLimit_ff);
            end else if (regAdr == osfs_pkg::OFF_PID_LOW) begin
                rdData_ff <= 32'(pidLow_ff);
            end else if (regAdr == osfs_pkg::OFF_PID_HIGH) begin
                rdData_ff <= 32'(pidHigh_ff);
            end else if (regAdr == osfs_pkg::OFF_WDT_PERIOD) begin
                rdData_ff <= wdtPeriod_ff;
            end else if (regAdr == osfs_pkg::OFF_LOGIC_CFG) begin
                rdData_ff <= 32'(logicCfg_ff);
            end else if (regAdr == osfs_pkg::OFF_HEAT_LIMIT) begin
                rdData_ff <= 32'(heatLimit_ff);
            end else if (regAdr == osfs_pkg::OFF_LOWLOAD_LIMIT) begin
                rdData_ff <= 32'(lowloadLimit_ff);
            end else if (regAdr == osfs_pkg::OFF_ARRIVE_BAND) begin
                rdData_ff <= 32'(arriveBand_ff);
            end else if (regAdr == osfs_pkg::OFF_FLAGS) begin
                rdData_ff <= 32'(flags_ff);
            end else if (regAdr == osfs_pkg::OFF_INT_STATUS) begin
                rdData_ff <= 32'(intStatus_ff);
            end else if (regAdr == osfs_pkg::OFF_INT_MASK) begin
                rdData_ff <= 32'(intMask_ff);
            end else begin
                rdData_ff <= osfs_pkg::RST_ZERO;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            termSel_ff <= osfs_pkg::RST_TERM_SEL;
            ovlLimit_ff <= DW'(osfs_pkg::RST_ZERO);
            vlossLimit_ff <= DW'(osfs_pkg::RST_ZERO);
            ilossLimit_ff <= DW'(osfs_pkg::RST_ZERO);
            pidLow_ff <= DW'(osfs_pkg::RST_ZERO);
            pidHigh_ff <= DW'(osfs_pkg::RST_ZERO);
            wdtPeriod_ff <= osfs_pkg::RST_WDT_PERIOD;
            logicCfg_ff <= 6'(osfs_pkg::RST_ZERO);
            heatLimit_ff <= DW'(osfs_pkg::RST_ZERO);
            lowloadLimit_ff <= DW'(osfs_pkg::RST_ZERO);
            arriveBand_ff <= DW'(osfs_pkg::RST_ZERO);
            intMask_ff <= osfs_pkg::FLAG_COUNT'(osfs_pkg::RST_ZERO);
        end else if (wrEn) begin
            if (regAdr == osfs_pkg::OFF_TERM_SEL) begin
                termSel_ff <= merge(termSel_ff, wb_dat_i, byteMask);
            end else if (regAdr == osfs_pkg::OFF_OVL_LIMIT) begin
                ovlLimit_ff <= DW'(merge(32'(ovlLimit_ff), wb_dat_i, byteMask));
            end else if (regAdr == osfs_pkg::OFF_VLOSS_LIMIT) begin
                vlossLimit_ff <= DW'(merge(32'(vlossLimit_ff), wb_dat_i, byteMask));
            end else if (regAdr == osfs_pkg::OFF_ILOSS_LIMIT) begin
                ilossLimit_ff <= DW'(merge(32'(ilossLimit_ff), wb_dat_i, byteMask));
            end else if (regAdr == osfs_pkg::OFF_PID_LOW) begin
                pidLow_ff <= DW'(merge(32'(pidLow_ff), wb_dat_i, byteMask));
            end else if (regAdr == osfs_pkg::OFF_PID_HIGH) begin
                pidHigh_ff <= DW'(merge(32'(pidHigh_ff), wb_dat_i, byteMask));
            end else if (regAdr == osfs_pkg::OFF_WDT_PERIOD) begin
                wdtPeriod_ff <= merge(wdtPeriod_ff, wb_dat_i, byteMask);
            end else if (regAdr == osfs_pkg::OFF_LOGIC_CFG) begin
                logicCfg_ff <= 6'(merge(32'(logicCfg_ff), wb_dat_i, byteMask));
            end else if (regAdr == osfs_pkg::OFF_HEAT_LIMIT) begin
                heatLimit_ff <= DW'(merge(32'(heatLimit_ff), wb_dat_i, byteMask));
            end else if (regAdr == osfs_pkg::OFF_LOWLOAD_LIMIT) begin
                lowloadLimit_ff <= DW'(merge(32'(lowloadLimit_ff), wb_dat_i, byteMask));
            end else if (regAdr == osfs_pkg::OFF_ARRIVE_BAND) begin
                arriveBand_ff <= DW'(merge(32'(arriveBand_ff), wb_dat_i, byteMask));
            end else if (regAdr == osfs_pkg::OFF_INT_MASK) begin
                intMask_ff <= osfs_pkg::FLAG_COUNT'(merge(32'(intMask_ff), wb_dat_i, byteMask));
            end
        end
    end

    // ------------------------------------------------------------
    // level flags and latched pid flag
    // ------------------------------------------------------------
    assign freqDiff = (outputFreq > setFreq) ? outputFreq - setFreq : setFreq - outputFreq;

    // each boolean output combines its own pair of inputs
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            case (osfs_pkg::osfs_bool_op_t'(logicCfg_ff[2*i +: 2]))
                osfs_pkg::OSFS_OP_AND: boolRes[i] = logicInA[i] & logicInB[i];
                osfs_pkg::OSFS_OP_OR: boolRes[i] = logicInA[i] | logicInB[i];
                osfs_pkg::OSFS_OP_XOR: boolRes[i] = logicInA[i] ^ logicInB[i];
                default: boolRes[i] = 1'b0;
            endcase
        end
    end

    always_comb begin
        nxt_flagsComb = flags_ff;
        // ramps do not mask arrival, only outputOn and the band do
        nxt_flagsComb[osfs_pkg::FB_ARRIVE] = outputOn && (freqDiff <= arriveBand_ff); // RQ1
        nxt_flagsComb[osfs_pkg::FB_OVERLOAD] = outputCurrent > ovlLimit_ff; // RQ2
        nxt_flagsComb[osfs_pkg::FB_VLOSS] = voltageInput < vlossLimit_ff; // RQ3
        nxt_flagsComb[osfs_pkg::FB_ILOSS] = currentInput < ilossLimit_ff; // RQ4
        nxt_flagsComb[osfs_pkg::FB_BOOL1 +: 3] = boolRes; // RQ8
        nxt_flagsComb[osfs_pkg::FB_CAP] = capacitorExpired; // RQ9
        nxt_flagsComb[osfs_pkg::FB_FAN] = fanExpired; // RQ10
        nxt_flagsComb[osfs_pkg::FB_START] = forward_run_command ^ reverse_run_command; // RQ11
        nxt_flagsComb[osfs_pkg::FB_HEAT] = heatsinkTemp > heatLimit_ff; // RQ12
        nxt_flagsComb[osfs_pkg::FB_LOWLOAD] = motorCurrent < lowloadLimit_ff; // RQ13
        // latched pid flag: clear wins over set when limits overlap
        if ((process_variable > pidHigh_ff) || (runPrev_ff && !runMode)) begin
            nxt_flagsComb[osfs_pkg::FB_PID] = 1'b0; // RQ6
        end else if (runMode && (process_variable < pidLow_ff)) begin
            nxt_flagsComb[osfs_pkg::FB_PID] = 1'b1; // RQ5
        end
        nxt_flagsComb[osfs_pkg::FB_NET] = (wdtPeriod_ff != 32'h00000000) && !commActivity
            && (wdtCount_ff >= wdtPeriod_ff); // RQ7
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_ff <= osfs_pkg::FLAG_COUNT'(osfs_pkg::RST_ZERO);
            flagsPrev_ff <= osfs_pkg::FLAG_COUNT'(osfs_pkg::RST_ZERO);
            runPrev_ff <= 1'b0;
        end else begin
            flags_ff <= nxt_flagsComb;
            flagsPrev_ff <= flags_ff;
            runPrev_ff <= runMode;
        end
    end

    // ------------------------------------------------------------
    // communications watchdog, saturating; zero period disables
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wdtCount_ff <= osfs_pkg::RST_ZERO;
        end else if (commActivity) begin
            wdtCount_ff <= osfs_pkg::RST_ZERO; // RQ7
        end else if (wdtCount_ff < wdtPeriod_ff) begin
            wdtCount_ff <= wdtCount_ff + 32'h00000001;
        end
    end

    // ------------------------------------------------------------
    // terminal selection, 8-bit code per terminal
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            termOut_ff <= '0;
        end else begin
            for (int t = 0; t < NUM_TERM; t++) begin
                case (termSel_ff[8*t +: 8]) // RQ14
                    osfs_pkg::OPT_ARRIVE: termOut_ff[t] <= flags_ff[osfs_pkg::FB_ARRIVE];
                    osfs_pkg::OPT_OVERLOAD: termOut_ff[t] <= flags_ff[osfs_pkg::FB_OVERLOAD];
                    osfs_pkg::OPT_VLOSS: termOut_ff[t] <= flags_ff[osfs_pkg::FB_VLOSS];
                    osfs_pkg::OPT_ILOSS: termOut_ff[t] <= flags_ff[osfs_pkg::FB_ILOSS];
                    osfs_pkg::OPT_PID: termOut_ff[t] <= flags_ff[osfs_pkg::FB_PID];
                    osfs_pkg::OPT_NET: termOut_ff[t] <= flags_ff[osfs_pkg::FB_NET];
                    osfs_pkg::OPT_BOOL1: termOut_ff[t] <= flags_ff[osfs_pkg::FB_BOOL1];
                    osfs_pkg::OPT_BOOL2: termOut_ff[t] <= flags_ff[osfs_pkg::FB_BOOL1 + 1];
                    osfs_pkg::OPT_BOOL3: termOut_ff[t] <= flags_ff[osfs_pkg::FB_BOOL1 + 2];
                    osfs_pkg::OPT_CAP: termOut_ff[t] <= flags_ff[osfs_pkg::FB_CAP];
                    osfs_pkg::OPT_FAN: termOut_ff[t] <= flags_ff[osfs_pkg::FB_FAN];
                    osfs_pkg::OPT_START: termOut_ff[t] <= flags_ff[osfs_pkg::FB_START];
                    osfs_pkg::OPT_HEAT: termOut_ff[t] <= flags_ff[osfs_pkg::FB_HEAT];
                    osfs_pkg::OPT_LOWLOAD: termOut_ff[t] <= flags_ff[osfs_pkg::FB_LOWLOAD];
                    default: termOut_ff[t] <= 1'b0; // RQ14
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts: rising flag sets sticky bit, set beats w1c
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            intStatus_ff <= osfs_pkg::FLAG_COUNT'(osfs_pkg::RST_ZERO);
        end else begin
            if (wrEn && regAdr == osfs_pkg::OFF_INT_STATUS) begin
                intStatus_ff <= (intStatus_ff
                    & ~osfs_pkg::FLAG_COUNT'(wb_dat_i & byteMask))
                    | (flags_ff & ~flagsPrev_ff);
            end else begin
                intStatus_ff <= intStatus_ff | (flags_ff & ~flagsPrev_ff);
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(intStatus_ff & intMask_ff);
        end
    end

    assign wb_ack_o = wb_ack_ff;
    assign wb_dat_o = rdData_ff;
    assign termOut = termOut_ff;
    assign irq = irq_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence runToStop;
        runMode ##1 !runMode;
    endsequence

    sequence pidSetCause;
        runMode && (process_variable < pidLow_ff) && (process_variable <= pidHigh_ff)
            && !(runPrev_ff && !runMode);
    endsequence

    AST_ARRIVE: assert property (!outputOn |=> !flags_ff[osfs_pkg::FB_ARRIVE]) // RQ1
        else $error("arrival flag set with output off");
    AST_OVERLOAD: assert property (outputCurrent > ovlLimit_ff
        |=> flags_ff[osfs_pkg::FB_OVERLOAD]) // RQ2
        else $error("overload flag missed");
    AST_VLOSS: assert property (voltageInput < vlossLimit_ff
        |=> flags_ff[osfs_pkg::FB_VLOSS]) // RQ3
        else $error("voltage loss flag missed");
    AST_ILOSS: assert property (currentInput >= ilossLimit_ff
        |=> !flags_ff[osfs_pkg::FB_ILOSS]) // RQ4
        else $error("current loss flag without loss");
    AST_PID_SET: assert property (pidSetCause |=> flags_ff[osfs_pkg::FB_PID]) // RQ5
        else $error("pid flag not set");
    AST_PID_STOP: assert property (runToStop |=> !flags_ff[osfs_pkg::FB_PID]) // RQ6
        else $error("pid flag not cleared on stop");
    AST_NET: assert property (commActivity |=> !flags_ff[osfs_pkg::FB_NET] [*2]) // RQ7
        else $error("network flag despite activity");
    AST_START: assert property (forward_run_command && reverse_run_command
        |=> !flags_ff[osfs_pkg::FB_START]) // RQ11
        else $error("start flag with both commands");
    AST_CAP: assert property (capacitorExpired |=> flags_ff[osfs_pkg::FB_CAP]) // RQ9
        else $error("capacitor flag missed");
    AST_FAN: assert property (!fanExpired |=> !flags_ff[osfs_pkg::FB_FAN]) // RQ10
        else $error("fan flag without expiry");
    AST_HEAT: assert property (heatsinkTemp > heatLimit_ff
        |=> flags_ff[osfs_pkg::FB_HEAT]) // RQ12
        else $error("overheat flag missed");
    AST_LOWLOAD: assert property (motorCurrent >= lowloadLimit_ff
        |=> !flags_ff[osfs_pkg::FB_LOWLOAD]) // RQ13
        else $error("low load flag wrong");
    AST_TERM_IDLE: assert property (termSel_ff[7:0] == 8'hff
        && $stable(termSel_ff) |=> !termOut_ff[0]) // RQ14
        else $error("unknown code drives terminal");
endmodule

`default_nettype wire

/* File: osfs_ctrl_equipment.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side equipment watching the terminals
// ----------------------------------------
module osfs_ctrl_equipment #(
    parameter int NUM_TERM = 2
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [NUM_TERM-1:0] termOut,
    output logic [NUM_TERM-1:0] seenTerm_ff
);
    // input card latches termOut at each edge, so seenTerm_ff trails it by one cycle and a one-cycle pulse is seen for one cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            seenTerm_ff <= '0;
        end else begin
            seenTerm_ff <= termOut;
        end
    end
endmodule
`default_nettype wire

/* File: output_status_flag_selector_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((e) !== (g)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module output_status_flag_selector_tb;
    // ----------------
    // signals
    // ----------------
    logic core_clk, reset_n, cyc, stb, we, ack, irq, outputOn, runMode, commActivity;
    logic capExp, fanExp, fwd, rev;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat;
    logic [15:0] oFreq, sFreq, oCur, vIn, iIn, procVar, heat, mCur;
    logic [2:0] inA, inB;
    logic [1:0] termOut, seen;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    osfs_selector #(.NUM_TERM(2), .DW(16)) dut_u (.core_clk(core_clk), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .outputOn(outputOn),
        .outputFreq(oFreq), .setFreq(sFreq), .outputCurrent(oCur), .voltageInput(vIn),
        .currentInput(iIn), .runMode(runMode), .process_variable(procVar),
        .commActivity(commActivity), .logicInA(inA), .logicInB(inB),
        .capacitorExpired(capExp), .fanExpired(fanExp), .forward_run_command(fwd),
        .reverse_run_command(rev), .heatsinkTemp(heat), .motorCurrent(mCur),
        .termOut(termOut), .irq(irq));
    osfs_ctrl_equipment #(.NUM_TERM(2)) equip_u (.core_clk(core_clk), .reset_n(reset_n),
        .termOut(termOut), .seenTerm_ff(seen));
    // ----------------
    // bus and checks
    // ----------------
    // entered just after a rising edge; ack is sampled at each edge, never assumed
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        `CHK("ackwait", 2, n)
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        `CHK("reg", e, q)
    endtask
    task automatic flg(input int b, input logic e);
        logic [31:0] q;
        repeat (2) @(posedge core_clk);
        xfer(1'b0, osfs_pkg::OFF_FLAGS, 32'h0, q);
        `CHK("flag", e, q[b])
    endtask
    task automatic complete_run();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------
    // clock, timeout, sequence
    // ----------------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // run takes well under a thousand cycles; a hang stops here
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        {reset_n, cyc, stb, we, adr, sel, dat, outputOn, runMode, commActivity} = '0;
        {capExp, fanExp, fwd, rev, oFreq, sFreq, oCur, vIn, iIn, procVar, heat, mCur} = '0;
        {inA, inB} = '0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rdChk(osfs_pkg::OFF_TERM_SEL, 32'hffffffff);
        rdChk(8'h3c, 32'h00000000);
        wr(osfs_pkg::OFF_TERM_SEL, 32'h00001d29);
        wr(osfs_pkg::OFF_INT_MASK, 32'h00000800);
        fwd <= 1'b1;
        flg(osfs_pkg::FB_START, 1'b1);
        `CHK("term", 2'h1, seen)
        `CHK("irq", 1'b1, irq)
        wr(osfs_pkg::OFF_INT_STATUS, 32'h00000800);
        `CHK("irqclr", 1'b0, irq)
        rev <= 1'b1;
        flg(osfs_pkg::FB_START, 1'b0);
        `CHK("term", 2'h0, seen)
        fwd <= 1'b0;
        flg(osfs_pkg::FB_START, 1'b1);
        rev <= 1'b0;
        flg(osfs_pkg::FB_START, 1'b0);
        wr(osfs_pkg::OFF_OVL_LIMIT, 32'h00000064);
        oCur <= 16'h0064;
        flg(osfs_pkg::FB_OVERLOAD, 1'b0);
        oCur <= 16'h0065;
        flg(osfs_pkg::FB_OVERLOAD, 1'b1);
        vIn <= 16'h0032;
        iIn <= 16'h0032;
        wr(osfs_pkg::OFF_VLOSS_LIMIT, 32'h00000032);
        wr(osfs_pkg::OFF_ILOSS_LIMIT, 32'h00000032);
        flg(osfs_pkg::FB_VLOSS, 1'b0);
        flg(osfs_pkg::FB_ILOSS, 1'b0);
        vIn <= 16'h0031;
        iIn <= 16'h0031;
        flg(osfs_pkg::FB_VLOSS, 1'b1);
        flg(osfs_pkg::FB_ILOSS, 1'b1);
        wr(osfs_pkg::OFF_HEAT_LIMIT, 32'h00000050);
        heat <= 16'h0050;
        flg(osfs_pkg::FB_HEAT, 1'b0);
        heat <= 16'h0051;
        flg(osfs_pkg::FB_HEAT, 1'b1);
        mCur <= 16'h001e;
        wr(osfs_pkg::OFF_LOWLOAD_LIMIT, 32'h0000001e);
        flg(osfs_pkg::FB_LOWLOAD, 1'b0);
        mCur <= 16'h001d;
        flg(osfs_pkg::FB_LOWLOAD, 1'b1);
        wr(osfs_pkg::OFF_ARRIVE_BAND, 32'h00000002);
        sFreq <= 16'h03e8;
        oFreq <= 16'h03eb;
        outputOn <= 1'b1;
        flg(osfs_pkg::FB_ARRIVE, 1'b0);
        oFreq <= 16'h03ea;
        flg(osfs_pkg::FB_ARRIVE, 1'b1);
        outputOn <= 1'b0;
        flg(osfs_pkg::FB_ARRIVE, 1'b0);
        wr(osfs_pkg::OFF_PID_LOW, 32'h00000064);
        wr(osfs_pkg::OFF_PID_HIGH, 32'h000000c8);
        procVar <= 16'h0063;
        flg(osfs_pkg::FB_PID, 1'b0);
        runMode <= 1'b1;
        flg(osfs_pkg::FB_PID, 1'b1);
        procVar <= 16'h00c8;
        flg(osfs_pkg::FB_PID, 1'b1);
        procVar <= 16'h00c9;
        flg(osfs_pkg::FB_PID, 1'b0);
        procVar <= 16'h0063;
        flg(osfs_pkg::FB_PID, 1'b1);
        runMode <= 1'b0;
        flg(osfs_pkg::FB_PID, 1'b0);
        inA <= 3'b110;
        inB <= 3'b010;
        wr(osfs_pkg::OFF_LOGIC_CFG, 32'h00000024);
        flg(osfs_pkg::FB_BOOL1, 1'b0);
        flg(osfs_pkg::FB_BOOL1 + 1, 1'b1);
        flg(osfs_pkg::FB_BOOL1 + 2, 1'b1);
        wr(osfs_pkg::OFF_LOGIC_CFG, 32'h00000006);
        flg(osfs_pkg::FB_BOOL1 + 2, 1'b0);
        // operator code 3 has no function and forces zero
        wr(osfs_pkg::OFF_LOGIC_CFG, 32'h0000000c);
        flg(osfs_pkg::FB_BOOL1 + 1, 1'b0);
        // start flag rose again above; drop its sticky bit first
        wr(osfs_pkg::OFF_INT_STATUS, 32'h00000800);
        capExp <= 1'b1;
        flg(osfs_pkg::FB_CAP, 1'b1);
        `CHK("irqmask", 1'b0, irq)
        fanExp <= 1'b1;
        flg(osfs_pkg::FB_FAN, 1'b1);
        commActivity <= 1'b1;
        wr(osfs_pkg::OFF_WDT_PERIOD, 32'h00000014);
        repeat (30) @(posedge core_clk);
        flg(osfs_pkg::FB_NET, 1'b0);
        commActivity <= 1'b0;
        repeat (30) @(posedge core_clk);
        flg(osfs_pkg::FB_NET, 1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
